// *** verilog/plc_dpram_diagnostic_map.sv ***
// shared memory, access rights and diagnosis words of the controller card
//
// Contract
// - diag two high byte: station or 255
// - master-side fault codes 50-65, 202, 212, 213
// - bus-side fault codes 2, 3, 9, 17, 18
// - diag one high byte: run, init, firmware flags
// - stop fault as E1-E7 or FF code
// - 512-byte read and write data-block windows
// - coupling flags: inputs host-read, outputs host-written
// - coupling output block then seven input blocks
// - fast-transfer region shared read/write both sides
`timescale 1ns/10ps
module plc_dpram_diagnostic_map #(
    parameter int ADDR_W = plc_dpram_pkg::ADDR_W,
    parameter int DATA_W = plc_dpram_pkg::DATA_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    // host bus pins, word addressed, four-phase request/acknowledge
    input wire logic host_req,
    input wire logic host_we,
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic [DATA_W-1:0] host_wdata,
    output logic host_ack,
    output logic host_denied,
    output logic [DATA_W-1:0] host_rdata,
    // controller side, same clock
    input wire logic ctl_req,
    input wire logic ctl_we,
    input wire logic [ADDR_W-1:0] ctl_addr,
    input wire logic [DATA_W-1:0] ctl_wdata,
    output logic ctl_ack,
    output logic [DATA_W-1:0] ctl_rdata,
    // master status and faults from the controller
    input wire logic master_fw_ok,
    input wire logic master_init_done,
    input wire logic master_cyclic,
    input wire logic [7:0] master_low_status,
    input wire logic fault_in_master,
    input wire logic [7:0] fault_station,
    input wire logic [7:0] fault_code,
    input wire logic [3:0] stop_cause,
    output logic fault_code_illegal,
    // interrupt words written by the host
    output logic [DATA_W-1:0] interrupt_selection,
    output logic [DATA_W-1:0] stacked_bus_interrupt_choice,
    output logic [DATA_W-1:0] isa_interrupt_word
);
    // the map decode is fixed to a 4096-word array of 16-bit words
    if (ADDR_W != 12 || DATA_W != 16) begin : g_bad_width
        $error("map needs 12 address bits and 16 data bits");
    end

    function automatic logic [ADDR_W-1:0] widx(input logic [12:0] ofs);
        return ofs[12:1];
    endfunction : widx

    function automatic logic in_rng(input logic [ADDR_W-1:0] a, input logic [12:0] ofs,
                                    input logic [12:0] len);
        logic [13:0] b;
        b = {1'b0, a, 1'b0};
        return (b >= {1'b0, ofs}) && (b < ({1'b0, ofs} + {1'b0, len}));
    endfunction : in_rng

    function automatic logic host_may_write(input logic [ADDR_W-1:0] a);
        logic ok;
        ok = in_rng(a, plc_dpram_pkg::OFS_CFLAG_OUT, plc_dpram_pkg::LEN_CFLAG);
        ok = ok || in_rng(a, plc_dpram_pkg::OFS_DB_WRITE, plc_dpram_pkg::LEN_DB);
        ok = ok || in_rng(a, plc_dpram_pkg::OFS_COMM, plc_dpram_pkg::LEN_COMM);
        ok = ok || in_rng(a, plc_dpram_pkg::OFS_CPL_IN1,
                          plc_dpram_pkg::OFS_FAST - plc_dpram_pkg::OFS_CPL_IN1);
        ok = ok || in_rng(a, plc_dpram_pkg::OFS_FAST, plc_dpram_pkg::LEN_FAST);
        ok = ok || in_rng(a, plc_dpram_pkg::OFS_SEMA, plc_dpram_pkg::LEN_SEMA);
        ok = ok || (a >= widx(plc_dpram_pkg::OFS_IRQ_SEL));
        return ok;
    endfunction : host_may_write

    function automatic logic hw_owned(input logic [ADDR_W-1:0] a);
        return a == widx(plc_dpram_pkg::OFS_DIAG_ONE) || a == widx(plc_dpram_pkg::OFS_DIAG_TWO)
            || a == widx(plc_dpram_pkg::OFS_STOP_FAULT);
    endfunction : hw_owned

    function automatic logic master_code_ok(input logic [7:0] c);
        return (c >= 8'h32 && c <= 8'h41) || c == 8'hCA || c == 8'hD4 || c == 8'hD5;
    endfunction : master_code_ok

    function automatic logic bus_code_ok(input logic [7:0] c);
        return c == 8'h02 || c == 8'h03 || c == 8'h09 || c == 8'h11 || c == 8'h12;
    endfunction : bus_code_ok

    // host pins through two flip-flops
    logic [1+ADDR_W+DATA_W:0] hs1_r;
    logic [1+ADDR_W+DATA_W:0] hs2_r;
    logic h_req_s;
    logic h_we_s;
    logic [ADDR_W-1:0] h_addr_s;
    logic [DATA_W-1:0] h_wdata_s;
    assign {h_req_s, h_we_s, h_addr_s, h_wdata_s} = hs2_r;

    // storage and state
    localparam int DEPTH_FIX = plc_dpram_pkg::DEPTH;
    logic [DATA_W-1:0] mem_r [DEPTH_FIX];
    logic host_ack_r;
    logic host_ack_nxt;
    logic host_denied_r;
    logic host_denied_nxt;
    logic [DATA_W-1:0] host_rdata_r;
    logic [DATA_W-1:0] host_rdata_nxt;
    logic ctl_ack_r;
    logic [DATA_W-1:0] ctl_rdata_r;
    logic [DATA_W-1:0] ctl_rdata_nxt;
    logic [DATA_W-1:0] diag_one_r;
    logic [DATA_W-1:0] diag_one_nxt;
    logic [DATA_W-1:0] diag_two_r;
    logic [DATA_W-1:0] diag_two_nxt;
    logic [DATA_W-1:0] stop_word_r;
    logic [DATA_W-1:0] stop_word_nxt;
    logic illegal_r;
    logic illegal_nxt;
    logic [DATA_W-1:0] irq_sel_r;
    logic [DATA_W-1:0] irq_sel_nxt;
    logic [DATA_W-1:0] irq_stack_r;
    logic [DATA_W-1:0] irq_stack_nxt;
    logic [DATA_W-1:0] irq_isa_r;
    logic [DATA_W-1:0] irq_isa_nxt;
    logic wr_en;
    logic [ADDR_W-1:0] wr_idx;
    logic [DATA_W-1:0] wr_data;
    logic grant_host;
    logic grant_ctl;

    function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a,
                                                     input logic [DATA_W-1:0] m);
        if (a == widx(plc_dpram_pkg::OFS_DIAG_ONE)) begin
            return diag_one_r;
        end else if (a == widx(plc_dpram_pkg::OFS_DIAG_TWO)) begin
            return diag_two_r;
        end else if (a == widx(plc_dpram_pkg::OFS_STOP_FAULT)) begin
            return stop_word_r;
        end
        return m;
    endfunction : read_word

    // one whole word per grant
    dpram_arbiter u_arbiter (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .host_want(h_req_s && !host_ack_r),
        .ctl_want(ctl_req && !ctl_ack_r),
        .grant_host(grant_host),
        .grant_ctl(grant_ctl)
    );

    always_comb begin
        host_ack_nxt = host_ack_r;
        host_denied_nxt = host_denied_r;
        host_rdata_nxt = host_rdata_r;
        ctl_rdata_nxt = ctl_rdata_r;
        irq_sel_nxt = irq_sel_r;
        irq_stack_nxt = irq_stack_r;
        irq_isa_nxt = irq_isa_r;
        wr_en = 1'b0;
        wr_idx = ctl_addr;
        wr_data = ctl_wdata;
        if (!h_req_s) begin
            host_ack_nxt = 1'b0;
            host_denied_nxt = 1'b0;
        end
        if (grant_host) begin
            host_ack_nxt = 1'b1;
            host_rdata_nxt = read_word(h_addr_s, mem_r[h_addr_s]);
            host_denied_nxt = h_we_s && !host_may_write(h_addr_s);
            if (h_we_s && host_may_write(h_addr_s)) begin
                wr_en = 1'b1;
                wr_idx = h_addr_s;
                wr_data = h_wdata_s;
            end
            if (h_we_s && h_addr_s == widx(plc_dpram_pkg::OFS_IRQ_SEL)) begin
                irq_sel_nxt = h_wdata_s;
            end
            if (h_we_s && h_addr_s == widx(plc_dpram_pkg::OFS_IRQ_STACK)) begin
                irq_stack_nxt = h_wdata_s;
            end
            if (h_we_s && h_addr_s == widx(plc_dpram_pkg::OFS_IRQ_ISA)) begin
                irq_isa_nxt = h_wdata_s;
            end
        end
        if (grant_ctl) begin
            ctl_rdata_nxt = read_word(ctl_addr, mem_r[ctl_addr]);
            wr_en = ctl_we && !hw_owned(ctl_addr);
        end
    end

    always_comb begin
        diag_one_nxt = {5'h00, master_fw_ok, master_init_done, master_cyclic,
                        master_low_status};
        diag_one_nxt[plc_dpram_pkg::MAIN_RUN_BIT] = master_cyclic;
        diag_one_nxt[plc_dpram_pkg::MAIN_INIT_BIT] = master_init_done;
        diag_one_nxt[plc_dpram_pkg::MAIN_FW_BIT] = master_fw_ok;
        illegal_nxt = 1'b0;
        if (fault_in_master) begin
            diag_two_nxt = {plc_dpram_pkg::MASTER_STATION, fault_code};
            if (!master_code_ok(fault_code)) begin
                diag_two_nxt[7:0] = plc_dpram_pkg::NO_FAULT;
                illegal_nxt = fault_code != plc_dpram_pkg::NO_FAULT;
            end
        end else begin
            diag_two_nxt = {fault_station, fault_code};
            if (!bus_code_ok(fault_code)) begin
                diag_two_nxt[7:0] = plc_dpram_pkg::NO_FAULT;
                illegal_nxt = fault_code != plc_dpram_pkg::NO_FAULT;
            end
        end
        unique case (stop_cause)
            plc_dpram_pkg::STOP_NONE: stop_word_nxt = 16'h0000;
            plc_dpram_pkg::STOP_LOAD1, plc_dpram_pkg::STOP_LOAD2, plc_dpram_pkg::STOP_LOAD3,
            plc_dpram_pkg::STOP_LOAD4, plc_dpram_pkg::STOP_LOAD5: begin
                stop_word_nxt = {8'h00, plc_dpram_pkg::STOP_LOAD_BASE | {4'h0, stop_cause}};
            end
            plc_dpram_pkg::STOP_MISSING: stop_word_nxt = {8'h00, plc_dpram_pkg::STOP_NO_MASTER};
            plc_dpram_pkg::STOP_DEAD: stop_word_nxt = {8'h00, plc_dpram_pkg::STOP_MASTER_DEAD};
            plc_dpram_pkg::STOP_POWER: stop_word_nxt = {8'h00, plc_dpram_pkg::STOP_POWER_LOSS};
            default: stop_word_nxt = stop_word_r;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hs1_r <= '0;
            hs2_r <= '0;
            host_ack_r <= 1'b0;
            host_denied_r <= 1'b0;
            host_rdata_r <= 16'h0000;
            ctl_ack_r <= 1'b0;
            ctl_rdata_r <= 16'h0000;
            diag_one_r <= 16'h0000;
            diag_two_r <= 16'h0000;
            stop_word_r <= 16'h0000;
            illegal_r <= 1'b0;
            irq_sel_r <= 16'h0000;
            irq_stack_r <= 16'h0000;
            irq_isa_r <= 16'h0000;
        end else begin
            hs1_r <= {host_req, host_we, host_addr, host_wdata};
            hs2_r <= hs1_r;
            host_ack_r <= host_ack_nxt;
            host_denied_r <= host_denied_nxt;
            host_rdata_r <= host_rdata_nxt;
            ctl_ack_r <= grant_ctl;
            ctl_rdata_r <= ctl_rdata_nxt;
            diag_one_r <= diag_one_nxt;
            diag_two_r <= diag_two_nxt;
            stop_word_r <= stop_word_nxt;
            illegal_r <= illegal_nxt;
            irq_sel_r <= irq_sel_nxt;
            irq_stack_r <= irq_stack_nxt;
            irq_isa_r <= irq_isa_nxt;
        end
    end

    // memory contents carry no reset
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem_r[wr_idx] <= wr_data;
        end
    end

    assign host_ack = host_ack_r;
    assign host_denied = host_denied_r;
    assign host_rdata = host_rdata_r;
    assign ctl_ack = ctl_ack_r;
    assign ctl_rdata = ctl_rdata_r;
    assign fault_code_illegal = illegal_r;
    assign interrupt_selection = irq_sel_r;
    assign stacked_bus_interrupt_choice = irq_stack_r;
    assign isa_interrupt_word = irq_isa_r;
endmodule : plc_dpram_diagnostic_map

// *** verilog/plc_dpram_pkg.sv ***
// shared-memory map and diagnosis constants of the controller card
package plc_dpram_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int DEPTH = 4096;

    // byte offsets of the host-visible map
    localparam logic [12:0] OFS_CFLAG_IN = 13'h0500;
    localparam logic [12:0] OFS_CFLAG_OUT = 13'h0600;
    localparam logic [12:0] OFS_DB_READ = 13'h0700;
    localparam logic [12:0] OFS_DB_WRITE = 13'h0900;
    localparam logic [12:0] OFS_COMM = 13'h1000;
    localparam logic [12:0] OFS_STOP_FAULT = 13'h1042;
    localparam logic [12:0] OFS_DIAG_ONE = 13'h104C;
    localparam logic [12:0] OFS_DIAG_TWO = 13'h104E;
    localparam logic [12:0] OFS_CPL_OUT = 13'h1100;
    localparam logic [12:0] OFS_CPL_IN1 = 13'h1140;
    localparam logic [12:0] OFS_CPL_IN7 = 13'h12C0;
    localparam logic [12:0] OFS_FAST = 13'h1300;
    localparam logic [12:0] OFS_SEMA = 13'h1FE0;
    localparam logic [12:0] OFS_IRQ_SEL = 13'h1FFA;
    localparam logic [12:0] OFS_IRQ_STACK = 13'h1FFC;
    localparam logic [12:0] OFS_IRQ_ISA = 13'h1FFE;

    // region lengths in bytes
    localparam logic [12:0] LEN_CFLAG = 13'h0100;
    localparam logic [12:0] LEN_DB = 13'h0200;
    localparam logic [12:0] LEN_COMM = 13'h0100;
    localparam logic [12:0] LEN_CPL_BLK = 13'h0040;
    localparam logic [12:0] LEN_FAST = 13'h0C00;
    localparam logic [12:0] LEN_SEMA = 13'h001A;

    // diagnosis word layouts
    localparam logic [7:0] MASTER_STATION = 8'hFF;
    localparam int MAIN_RUN_BIT = 8;
    localparam int MAIN_INIT_BIT = 9;
    localparam int MAIN_FW_BIT = 10;
    localparam logic [7:0] NO_FAULT = 8'h00;

    // stop-fault codes
    localparam logic [7:0] STOP_LOAD_BASE = 8'hE0;
    localparam logic [7:0] STOP_NO_MASTER = 8'hE6;
    localparam logic [7:0] STOP_MASTER_DEAD = 8'hE7;
    localparam logic [7:0] STOP_POWER_LOSS = 8'hFF;

    typedef enum logic [3:0] {
        STOP_NONE = 4'h0,
        STOP_LOAD1 = 4'h1,
        STOP_LOAD2 = 4'h2,
        STOP_LOAD3 = 4'h3,
        STOP_LOAD4 = 4'h4,
        STOP_LOAD5 = 4'h5,
        STOP_MISSING = 4'h6,
        STOP_DEAD = 4'h7,
        STOP_POWER = 4'h8
    } stop_cause_t;
endpackage : plc_dpram_pkg

// *** verilog/dpram_arbiter.sv ***
// round-robin grant of the single memory port between host and controller
`timescale 1ns/10ps
module dpram_arbiter (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic host_want,
    input wire logic ctl_want,
    output logic grant_host,
    output logic grant_ctl
);
    logic host_last_r;
    logic host_last_nxt;

    always_comb begin
        grant_host = 1'b0;
        grant_ctl = 1'b0;
        if (host_want && ctl_want) begin
            grant_host = !host_last_r;
            grant_ctl = host_last_r;
        end else begin
            grant_host = host_want;
            grant_ctl = ctl_want;
        end
        host_last_nxt = host_last_r;
        if (grant_host) begin
            host_last_nxt = 1'b1;
        end else if (grant_ctl) begin
            host_last_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_last_r <= 1'b0;
        end else begin
            host_last_r <= host_last_nxt;
        end
    end
endmodule : dpram_arbiter

// *** verif/plc_dpram_map_assertions.sv ***
// concurrent checks on the host and controller ports, diagnosis flag and interrupt word
`timescale 1ns/10ps
module plc_dpram_map_assertions (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic host_we,
    input wire logic [11:0] host_addr,
    input wire logic [15:0] host_wdata,
    input wire logic host_ack,
    input wire logic host_denied,
    input wire logic [15:0] interrupt_selection,
    input wire logic ctl_req,
    input wire logic ctl_ack,
    input wire logic fault_in_master,
    input wire logic [7:0] fault_code,
    input wire logic fault_code_illegal
);
    logic ack_r;
    logic ack_nxt;
    logic take;
    always_comb ack_nxt = host_ack;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) ack_r <= 1'b0;
        else ack_r <= ack_nxt;
    end
    // first ack cycle of a host write
    assign take = host_ack && !ack_r && host_we;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    AST_DENY_ACK: assert property (host_denied |-> host_ack)
        else $error("denied without ack");
    AST_RD_SERVED: assert property (host_ack && !ack_r && !host_we |-> !host_denied)
        else $error("read denied");
    AST_CFLAG_IN_RO: assert property (take && host_addr[11:7] == 5'h05 |-> host_denied)
        else $error("flag input write kept");
    AST_DBR_RO: assert property (take && host_addr >= 12'h380 && host_addr < 12'h480
        |-> host_denied)
        else $error("read window write kept");
    AST_DBW_OK: assert property (take && host_addr >= 12'h480 && host_addr < 12'h580
        |-> !host_denied)
        else $error("write window refused");
    AST_CPL_OUT_RO: assert property (take && host_addr[11:5] == 7'h44 |-> host_denied)
        else $error("coupling output write kept");
    AST_FAST_OK: assert property (take && host_addr >= 12'h980 && host_addr < 12'hF80
        |-> !host_denied)
        else $error("fast region refused");
    AST_IRQ_SEL: assert property (take && host_addr == 12'hFFD
        |-> ##[0:2] interrupt_selection == host_wdata)
        else $error("selection word not taken");
    AST_ILL_MST: assert property ((fault_in_master && fault_code == 8'h02) [*2]
        |-> fault_code_illegal)
        else $error("bus code in master class");
    AST_CTL_ANS: assert property ($rose(ctl_req) |-> ##[1:2] ctl_ack)
        else $error("controller not served");
endmodule : plc_dpram_map_assertions
bind plc_dpram_diagnostic_map plc_dpram_map_assertions plc_dpram_map_assertions_inst (
    .core_clk, .rst_n, .host_we, .host_addr, .host_wdata, .host_ack, .host_denied,
    .interrupt_selection, .ctl_req, .ctl_ack, .fault_in_master, .fault_code,
    .fault_code_illegal
);

// *** verif/host_model.sv ***
// host cpu model: four-phase word cycles on the card's host pins
`timescale 1ns/10ps
module host_model (
    input wire logic core_clk,
    output logic host_req,
    output logic host_we,
    output logic [11:0] host_addr,
    output logic [15:0] host_wdata,
    input wire logic host_ack,
    input wire logic host_denied,
    input wire logic [15:0] host_rdata
);
    initial begin
        host_req = 1'b0;
        host_we = 1'b0;
        host_addr = 12'h000;
        host_wdata = 16'h0000;
    end
    // whole words only, held until ack falls
    task automatic xfer(input logic we, input logic [11:0] a, input logic [15:0] d,
        output logic [15:0] rd, output logic den, output logic ok);
        int n;
        ok = 1'b0;
        @(posedge core_clk);
        #1;
        host_we = we;
        host_addr = a;
        host_wdata = d;
        repeat (2) @(posedge core_clk);
        #1;
        host_req = 1'b1;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge core_clk);
            ok = host_ack === 1'b1;
        end
        rd = host_rdata;
        den = host_denied;
        #1;
        host_req = 1'b0;
        for (n = 0; n < 20 && host_ack !== 1'b0; n++) begin
            @(posedge core_clk);
        end
        if (host_ack !== 1'b0) ok = 1'b0;
        #1;
        // released lines show no stale value
        host_wdata = ~host_wdata;
        host_addr = ~host_addr;
    endtask : xfer
endmodule : host_model

// *** verif/plc_dpram_diagnostic_map_bench.sv ***
// self-checking bench of the card's shared-memory map and diagnosis words
`timescale 1ns/10ps
module plc_dpram_diagnostic_map_bench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic host_req, host_we, host_ack, host_denied, ctl_ack, fault_code_illegal, den;
    logic [11:0] host_addr;
    logic [15:0] host_wdata, host_rdata, ctl_rdata, rd, rd2, p;
    logic ctl_req = 1'b0, ctl_we = 1'b0, fault_in_master = 1'b0;
    logic [11:0] ctl_addr = 12'h000;
    logic [15:0] ctl_wdata = 16'h0000;
    logic master_fw_ok = 1'b0, master_init_done = 1'b0, master_cyclic = 1'b0;
    logic [7:0] master_low_status = 8'h00, fault_station = 8'h05, fault_code = 8'h00;
    logic [3:0] stop_cause = 4'h0;
    logic [15:0] interrupt_selection, stacked_bus_interrupt_choice, isa_interrupt_word;
    int err_total = 0;
    int total_checks = 0;
    // byte offset, bit 0 set where the host may write
    logic [15:0] amap [16] = '{16'h0500, 16'h05FE, 16'h0601, 16'h06FF, 16'h0700, 16'h08FE,
        16'h0901, 16'h0AFF, 16'h0B00, 16'h1100, 16'h113E, 16'h1141, 16'h12C1, 16'h1301,
        16'h1EFF, 16'h1F00};
    // illegal, inside master, code
    logic [9:0] frow [28] = '{10'h132, 10'h133, 10'h134, 10'h135, 10'h136, 10'h137,
        10'h138, 10'h139, 10'h13A, 10'h13B, 10'h13C, 10'h13D, 10'h13E, 10'h13F, 10'h140,
        10'h141, 10'h1CA, 10'h1D4, 10'h1D5, 10'h002, 10'h003, 10'h009, 10'h011, 10'h012,
        10'h302, 10'h232, 10'h342, 10'h204};
    logic [7:0] stop_exp [9] = '{8'h00, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'hE7,
        8'hFF};
    always #2 core_clk = ~core_clk;
    host_model host_model_inst (.core_clk, .host_req, .host_we, .host_addr, .host_wdata,
        .host_ack, .host_denied, .host_rdata);
    plc_dpram_diagnostic_map plc_dpram_diagnostic_map_inst (.core_clk, .rst_n, .host_req,
        .host_we, .host_addr, .host_wdata, .host_ack, .host_denied, .host_rdata, .ctl_req,
        .ctl_we, .ctl_addr, .ctl_wdata, .ctl_ack, .ctl_rdata, .master_fw_ok,
        .master_init_done, .master_cyclic, .master_low_status, .fault_in_master,
        .fault_station, .fault_code, .stop_cause, .fault_code_illegal, .interrupt_selection,
        .stacked_bus_interrupt_choice, .isa_interrupt_word);
    task automatic print_verdict;
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic hx(input logic we, input logic [11:0] a, input logic [15:0] d,
        output logic [15:0] r, output logic dn);
        logic ok;
        host_model_inst.xfer(we, a, d, r, dn, ok);
        if (ok !== 1'b1) begin
            err_total++;
            print_verdict();
        end
    endtask : hx
    task automatic cx(input logic we, input logic [11:0] a, input logic [15:0] d,
        output logic [15:0] r);
        int n;
        @(posedge core_clk);
        #1;
        ctl_we = we;
        ctl_addr = a;
        ctl_wdata = d;
        ctl_req = 1'b1;
        for (n = 0; n < 10 && ctl_ack !== 1'b1; n++) begin
            @(posedge core_clk);
        end
        r = ctl_rdata;
        if (n == 10) begin
            err_total++;
            print_verdict();
        end
        #1;
        ctl_req = 1'b0;
        ctl_wdata = ~ctl_wdata;
    endtask : cx
    initial begin
        repeat (16) @(posedge core_clk);
        cmp("ack in reset", 16'h0000, {15'h0000, host_ack});
        #1;
        rst_n = 1'b1;
        foreach (amap[i]) begin
            p = amap[i] ^ 16'h5A5A;
            cx(1'b1, amap[i][12:1], p, rd);
            hx(1'b1, amap[i][12:1], ~p, rd, den);
            cmp("denied", {15'h0000, !amap[i][0]}, {15'h0000, den});
            hx(1'b0, amap[i][12:1], 16'h0000, rd, den);
            cmp("host word", amap[i][0] ? ~p : p, rd);
            cx(1'b0, amap[i][12:1], 16'h0000, rd);
            cmp("ctl word", amap[i][0] ? ~p : p, rd);
        end
        foreach (frow[i]) begin
            fault_in_master = frow[i][8];
            fault_code = frow[i][7:0];
            hx(1'b0, 12'h827, 16'h0000, rd, den);
            p = {frow[i][8] ? 8'hFF : 8'h05, frow[i][9] ? 8'h00 : frow[i][7:0]};
            cmp("diag two", p, rd);
            cmp("illegal", {15'h0000, frow[i][9]}, {15'h0000, fault_code_illegal});
        end
        cx(1'b1, 12'h827, 16'hFFFF, rd);
        hx(1'b0, 12'h827, 16'h0000, rd, den);
        cmp("owned word", p, rd);
        for (int i = 0; i < 8; i++) begin
            {master_fw_ok, master_init_done, master_cyclic} = i[2:0];
            master_low_status = 8'hA5 ^ i[7:0];
            hx(1'b0, 12'h826, 16'h0000, rd, den);
            cmp("diag one", {5'h00, i[2:0], 8'hA5 ^ i[7:0]}, rd);
        end
        for (int i = 0; i < 10; i++) begin
            stop_cause = i[3:0];
            hx(1'b0, 12'h821, 16'h0000, rd, den);
            cmp("stop word", {8'h00, stop_exp[i > 8 ? 8 : i]}, rd);
        end
        for (int i = 0; i < 3; i++) begin
            hx(1'b1, 12'hFFD + i[11:0], 16'hC0DE + i[15:0], rd, den);
        end
        cmp("irq sel", 16'hC0DE, interrupt_selection);
        cmp("irq stack", 16'hC0DF, stacked_bus_interrupt_choice);
        cmp("irq isa", 16'hC0E0, isa_interrupt_word);
        cx(1'b1, 12'h980, 16'h1111, rd);
        fork
            hx(1'b0, 12'h980, 16'h0000, rd, den);
            begin
                repeat (3) @(posedge core_clk);
                cx(1'b1, 12'h980, 16'h2222, rd2);
            end
        join
        cmp("whole word", 16'h0001, {15'h0000, rd === 16'h1111 || rd === 16'h2222});
        rst_n = 1'b0;
        @(posedge core_clk);
        cmp("sel in reset", 16'h0000, interrupt_selection);
        cmp("flag in reset", 16'h0000, {15'h0000, fault_code_illegal});
        #1;
        rst_n = 1'b1;
        print_verdict();
    end
endmodule : plc_dpram_diagnostic_map_bench
